// ===== logic/cterm_pkg.sv
// Shared constants and types for the charge termination controller.
// Assumes a single 20 MHz clock and a plain strobe register port.
package cterm_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_SECOND_S = 1;
    localparam int SEC_CYCLES = TICK_SECOND_S * CLK_HZ;
    localparam int MIN_SECONDS = 60;
    localparam logic [5:0] MIN_LAST = 6'(MIN_SECONDS - 1);

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_VHOLD_LIMIT = 4'h1;
    localparam logic [3:0] ADDR_CHARGE_LIMIT = 4'h2;
    localparam logic [3:0] ADDR_TAPER_DIV = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_VHOLD_TIMER = 4'h5;
    localparam logic [3:0] ADDR_CHARGE_TIMER = 4'h6;

    localparam int CTRL_TAPER_EN = 0;
    localparam int CTRL_SUSPEND = 1;
    localparam int CTRL_AL_TAPER = 2;
    localparam int CTRL_AL_VHOLD = 3;
    localparam int CTRL_AL_FAULT = 4;
    localparam int CTRL_ARM = 5;

    localparam int ST_TAPER = 0;
    localparam int ST_VHOLD = 1;
    localparam int ST_FAULT = 2;
    localparam int ST_SUSP = 3;
    localparam int ST_CV = 4;
    localparam int ST_CHG = 5;
    localparam int ST_ARMED = 6;

    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [15:0] VHOLD_LIMIT_RST = 16'h3840;
    localparam logic [15:0] CHARGE_LIMIT_RST = 16'h0000;
    localparam logic [3:0] TAPER_DIV_RST = 4'ha;

    typedef enum logic [2:0] {
        CTERM_SUSPEND, CTERM_CHARGE, CTERM_DONE, CTERM_FAULT, CTERM_STORAGE
    } cterm_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } cterm_bus_t;

    typedef struct packed {
        logic aux_supply_good;
        logic input_above_minimum;
        logic input_above_battery;
        logic input_hyst_ok;
        logic freq_resistor_missing;
        logic cell_strap_error;
        logic overheat;
        logic thermistor_pause;
        logic constant_voltage;
        logic below_recharge;
        logic below_35pct;
        logic input_below_1v;
        logic [15:0] battery_current;
        logic [15:0] full_current;
    } cterm_sense_t;

    typedef struct packed {
        cterm_state_t state;
        logic [5:0] ctrl;
        logic [15:0] vhold_limit;
        logic [15:0] charge_limit;
        logic [3:0] taper_div;
        logic taper_flag;
        logic vhold_flag;
        logic fault_flag;
        logic [31:0] presc;
        logic [5:0] sec_in_min;
        logic [15:0] vhold_secs;
        logic [15:0] charge_mins;
        logic woke;
        logic drive_en;
        logic suspended;
        logic alert_b;
        logic storage;
        logic [15:0] rdata;
    } cterm_core_t;

    localparam cterm_core_t CORE_RST = '{
        state: CTERM_SUSPEND, ctrl: CTRL_RST, vhold_limit: VHOLD_LIMIT_RST,
        charge_limit: CHARGE_LIMIT_RST, taper_div: TAPER_DIV_RST,
        taper_flag: 1'b0, vhold_flag: 1'b0, fault_flag: 1'b0, presc: 32'h0,
        sec_in_min: 6'h0, vhold_secs: 16'h0, charge_mins: 16'h0, woke: 1'b0,
        drive_en: 1'b0, suspended: 1'b1, alert_b: 1'b1, storage: 1'b0,
        rdata: 16'h0000};
endpackage

// ===== logic/cterm_top.sv
// Charge cycle termination, recharge, suspend and storage-mode control.
// Assumes sense inputs are synchronous to clk_in and the register master
// follows the one-cycle strobe protocol with read data one cycle later.
//
// Behaviour
// - Start charge and hold timers per cycle.
// - Either timer expiry stops charging.
// - Hold limit 16 bits, seconds, reset 14400.
// - Charge limit minutes; zero disables timer.
// - Both running timers readable anytime.
// - Separate flags for fault and hold timeout.
// - Fault held until 35 percent, a suspend condition or reset.
// - Normal termination clears elapsed timer.
// - Suspend conditions clear the charge fault.
// - Optional taper termination in voltage hold.
// - First of three causes ends charging.
// - Hold timer termination always active.
// - Thermistor pause freezes both timers.
// - Alert per cause, gated by enable.
// - Flags show which cause raised alert.
// - Termination disables the switching drive.
// - Recharge below 97.5 percent, timers zeroed.
// - Power cycle or suspend pulse restarts.
// - Arm only; enter below 1V, wake above.
// - Latch stay-out once input above minimum.
// - Storage mode loses every setting.
// - Fault conditions suspend and report status.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module cterm_top #(
    parameter int SEC_CYCLES = cterm_pkg::SEC_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire cterm_pkg::cterm_bus_t bus_in,
    input wire cterm_pkg::cterm_sense_t sense_in,
    output logic [15:0] reg_rdata_out,
    output logic charger_enable_out,
    output logic suspended_out,
    output logic alert_b_out,
    output logic storage_mode_out
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync;
    logic rst_b;
    cterm_pkg::cterm_core_t q;
    cterm_pkg::cterm_core_t n;
    logic susp;
    logic run;
    logic sec_tick;
    logic taper_hit;
    logic store_go;
    logic [19:0] taper_scaled;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_b = rst_sync[1];

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // Input power loss shows up as input_above_battery falling, so a power
    // cycle passes through the suspended state and restarts the cycle.
    assign susp = q.ctrl[cterm_pkg::CTRL_SUSPEND] | ~sense_in.input_above_battery
        | ~sense_in.aux_supply_good | ~sense_in.input_above_minimum
        | sense_in.overheat | sense_in.freq_resistor_missing
        | sense_in.cell_strap_error;
    assign run = (q.state == cterm_pkg::CTERM_CHARGE) & ~sense_in.thermistor_pause;
    assign sec_tick = run & (q.presc == 32'(SEC_CYCLES - 1));
    // Taper reached when current times divisor falls to full scale or less.
    // Widen first, or it wraps.
    assign taper_scaled = 20'(sense_in.battery_current) * 20'(q.taper_div);
    assign taper_hit = taper_scaled <= {4'h0, sense_in.full_current};
    assign store_go = (q.ctrl[cterm_pkg::CTRL_ARM] | q.woke) & sense_in.input_below_1v
        & (q.state != cterm_pkg::CTERM_STORAGE);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = q;
        n.rdata = 16'h0000;

        if (run) begin
            n.presc = sec_tick ? 32'h0 : q.presc + 32'h1;
        end
        if (sec_tick) begin
            if (sense_in.constant_voltage) begin
                n.vhold_secs = q.vhold_secs + 16'h1;
            end
            if (q.charge_limit != 16'h0) begin
                if (q.sec_in_min == cterm_pkg::MIN_LAST) begin
                    n.sec_in_min = 6'h0;
                    n.charge_mins = q.charge_mins + 16'h1;
                end else begin
                    n.sec_in_min = q.sec_in_min + 6'h1;
                end
            end
        end

        if (bus_in.wr) begin
            case (bus_in.addr)
                cterm_pkg::ADDR_CTRL: begin
                    n.ctrl = bus_in.wdata[5:0];
                end
                cterm_pkg::ADDR_VHOLD_LIMIT: begin
                    n.vhold_limit = bus_in.wdata;
                end
                cterm_pkg::ADDR_CHARGE_LIMIT: begin
                    n.charge_limit = bus_in.wdata;
                end
                cterm_pkg::ADDR_TAPER_DIV: begin
                    n.taper_div = bus_in.wdata[3:0];
                end
                cterm_pkg::ADDR_STATUS: begin
                    // Write one to clear; a hardware set later below wins.
                    n.taper_flag = q.taper_flag & ~bus_in.wdata[cterm_pkg::ST_TAPER];
                    n.vhold_flag = q.vhold_flag & ~bus_in.wdata[cterm_pkg::ST_VHOLD];
                end
                default: begin
                end
            endcase
        end

        if (bus_in.rd) begin
            case (bus_in.addr)
                cterm_pkg::ADDR_CTRL: n.rdata = {10'h0, q.ctrl};
                cterm_pkg::ADDR_VHOLD_LIMIT: n.rdata = q.vhold_limit;
                cterm_pkg::ADDR_CHARGE_LIMIT: n.rdata = q.charge_limit;
                cterm_pkg::ADDR_TAPER_DIV: n.rdata = {12'h0, q.taper_div};
                cterm_pkg::ADDR_STATUS: begin
                    n.rdata[cterm_pkg::ST_TAPER] = q.taper_flag;
                    n.rdata[cterm_pkg::ST_VHOLD] = q.vhold_flag;
                    n.rdata[cterm_pkg::ST_FAULT] = q.fault_flag;
                    n.rdata[cterm_pkg::ST_SUSP] = q.suspended;
                    n.rdata[cterm_pkg::ST_CV] = sense_in.constant_voltage;
                    n.rdata[cterm_pkg::ST_CHG] = q.drive_en;
                    n.rdata[cterm_pkg::ST_ARMED] = q.ctrl[cterm_pkg::CTRL_ARM];
                end
                cterm_pkg::ADDR_VHOLD_TIMER: n.rdata = q.vhold_secs;
                cterm_pkg::ADDR_CHARGE_TIMER: n.rdata = q.charge_mins;
                default: n.rdata = 16'h0000;
            endcase
        end

        case (q.state)
            cterm_pkg::CTERM_SUSPEND: begin
                if (!susp && sense_in.input_hyst_ok) begin
                    n.state = cterm_pkg::CTERM_CHARGE;
                    n.presc = 32'h0;
                    n.sec_in_min = 6'h0;
                    n.vhold_secs = 16'h0;
                    n.charge_mins = 16'h0;
                end
            end
            cterm_pkg::CTERM_CHARGE: begin
                if (susp) begin
                    n.state = cterm_pkg::CTERM_SUSPEND;
                end else if (q.charge_limit != 16'h0 && q.charge_mins >= q.charge_limit) begin
                    n.state = cterm_pkg::CTERM_FAULT;
                    n.fault_flag = 1'b1;
                end else if (sense_in.constant_voltage && q.vhold_secs >= q.vhold_limit) begin
                    // No enable guards this branch: it cannot be turned off.
                    n.state = cterm_pkg::CTERM_DONE;
                    n.vhold_flag = 1'b1;
                    n.charge_mins = 16'h0;
                    n.sec_in_min = 6'h0;
                end else if (q.ctrl[cterm_pkg::CTRL_TAPER_EN] && sense_in.constant_voltage
                        && taper_hit) begin
                    n.state = cterm_pkg::CTERM_DONE;
                    n.taper_flag = 1'b1;
                    n.charge_mins = 16'h0;
                    n.sec_in_min = 6'h0;
                end
            end
            cterm_pkg::CTERM_DONE: begin
                if (susp) begin
                    n.state = cterm_pkg::CTERM_SUSPEND;
                end else if (sense_in.below_recharge) begin
                    n.state = cterm_pkg::CTERM_CHARGE;
                    n.presc = 32'h0;
                    n.sec_in_min = 6'h0;
                    n.vhold_secs = 16'h0;
                    n.charge_mins = 16'h0;
                end
            end
            cterm_pkg::CTERM_FAULT: begin
                if (susp) begin
                    n.state = cterm_pkg::CTERM_SUSPEND;
                end else if (sense_in.below_35pct) begin
                    n.state = cterm_pkg::CTERM_CHARGE;
                    n.fault_flag = 1'b0;
                    n.presc = 32'h0;
                    n.sec_in_min = 6'h0;
                    n.vhold_secs = 16'h0;
                    n.charge_mins = 16'h0;
                end
            end
            cterm_pkg::CTERM_STORAGE: begin
                // Waking is a full power-up; only the pending wake is kept.
                if (!sense_in.input_below_1v) begin
                    n = cterm_pkg::CORE_RST;
                    n.woke = 1'b1;
                end
            end
            default: begin
                n.state = cterm_pkg::CTERM_SUSPEND;
            end
        endcase

        if (susp) begin
            n.fault_flag = 1'b0;
        end
        if (q.woke && sense_in.input_above_minimum) begin
            n.woke = 1'b0;
        end
        if (store_go) begin
            n = cterm_pkg::CORE_RST;
            n.state = cterm_pkg::CTERM_STORAGE;
        end

        n.drive_en = (n.state == cterm_pkg::CTERM_CHARGE);
        n.suspended = (n.state == cterm_pkg::CTERM_SUSPEND);
        n.storage = (n.state == cterm_pkg::CTERM_STORAGE);
        n.alert_b = ~((n.taper_flag & n.ctrl[cterm_pkg::CTRL_AL_TAPER])
            | (n.vhold_flag & n.ctrl[cterm_pkg::CTRL_AL_VHOLD])
            | (n.fault_flag & n.ctrl[cterm_pkg::CTRL_AL_FAULT]));
    end

    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            q <= cterm_pkg::CORE_RST;
        end else begin
            q <= n;
        end
    end

    assign reg_rdata_out = q.rdata;
    assign charger_enable_out = q.drive_en;
    assign suspended_out = q.suspended;
    assign alert_b_out = q.alert_b;
    assign storage_mode_out = q.storage;

    ////////////////////////////////////////////////////////////////////////
    sequence s_calm;
        !susp && !sense_in.input_below_1v;
    endsequence

    sequence s_paused_charge;
        (q.state == cterm_pkg::CTERM_CHARGE && sense_in.thermistor_pause) ##1
            (q.state == cterm_pkg::CTERM_CHARGE);
    endsequence

    chk_charge_fault_set: assert property (
        (q.state == cterm_pkg::CTERM_CHARGE && q.charge_limit != 16'h0
            && q.charge_mins >= q.charge_limit) and s_calm
        |=> q.fault_flag && !charger_enable_out && q.state == cterm_pkg::CTERM_FAULT)
        else $error("charge time limit did not raise the fault");

    chk_vhold_timeout: assert property (
        (q.state == cterm_pkg::CTERM_CHARGE && q.charge_mins < q.charge_limit
            && sense_in.constant_voltage && q.vhold_secs >= q.vhold_limit) and s_calm
        |=> q.vhold_flag && !charger_enable_out && q.charge_mins == 16'h0)
        else $error("voltage hold expiry did not terminate");

    chk_timer_freeze: assert property (
        s_paused_charge |-> $stable(q.vhold_secs) && $stable(q.charge_mins))
        else $error("timers moved during thermistor pause");

    chk_fault_hold: assert property (
        (q.state == cterm_pkg::CTERM_FAULT && !sense_in.below_35pct) and s_calm
        |=> q.state == cterm_pkg::CTERM_FAULT && q.fault_flag)
        else $error("charge fault released early");

    chk_fault_clear: assert property (
        susp |=> !q.fault_flag && !charger_enable_out)
        else $error("suspend condition left fault or drive on");

    chk_recharge_restart: assert property (
        (q.state == cterm_pkg::CTERM_DONE && sense_in.below_recharge) and s_calm
        |=> charger_enable_out && q.vhold_secs == 16'h0 && q.charge_mins == 16'h0)
        else $error("recharge did not restart with zeroed timers");

    chk_resume_cycle: assert property (
        (q.state == cterm_pkg::CTERM_SUSPEND && sense_in.input_hyst_ok) and s_calm
        |=> q.state == cterm_pkg::CTERM_CHARGE && !suspended_out && q.vhold_secs == 16'h0)
        else $error("leaving suspend did not start a cycle");

    chk_disabled_timer: assert property (
        q.charge_limit == 16'h0 && q.charge_mins == 16'h0 |=> q.charge_mins == 16'h0)
        else $error("elapsed timer ran while disabled");

    chk_alert_cause: assert property (
        $fell(alert_b_out) |-> (q.taper_flag && q.ctrl[cterm_pkg::CTRL_AL_TAPER])
            || (q.vhold_flag && q.ctrl[cterm_pkg::CTRL_AL_VHOLD])
            || (q.fault_flag && q.ctrl[cterm_pkg::CTRL_AL_FAULT]))
        else $error("alert without an enabled cause");

    chk_storage_wake: assert property (
        q.state == cterm_pkg::CTERM_STORAGE && !sense_in.input_below_1v
        |=> q.ctrl == cterm_pkg::CTRL_RST && q.vhold_limit == cterm_pkg::VHOLD_LIMIT_RST
            && !storage_mode_out)
        else $error("wake from storage kept settings");

    chk_read_timer: assert property (
        bus_in.rd && bus_in.addr == cterm_pkg::ADDR_VHOLD_TIMER
            && !store_go && q.state != cterm_pkg::CTERM_STORAGE
        |=> reg_rdata_out == $past(q.vhold_secs))
        else $error("voltage hold timer read wrong");

    // Taper end needs the taper enable, voltage hold and current at taper.
    sequence s_taper_reached;
        q.ctrl[cterm_pkg::CTRL_TAPER_EN] && sense_in.constant_voltage && taper_hit;
    endsequence

    chk_taper_end: assert property (
        (q.state == cterm_pkg::CTERM_CHARGE && q.charge_mins < q.charge_limit
            && q.vhold_secs < q.vhold_limit) and s_taper_reached and s_calm
        |=> q.taper_flag && !charger_enable_out)
        else $error("taper end missed");

    chk_hold_count: assert property (
        sec_tick && sense_in.constant_voltage && !sense_in.input_below_1v
        |=> q.vhold_secs == $past(q.vhold_secs) + 16'h1)
        else $error("hold timer missed");

    chk_suspend_report: assert property (
        susp && !sense_in.input_below_1v |=> suspended_out && !charger_enable_out)
        else $error("suspend not reported");

    chk_storage_enter: assert property (
        store_go |=> storage_mode_out && !charger_enable_out)
        else $error("storage not entered");

endmodule

// ===== tb/cterm_batt_model.sv
// Behavioural model of the battery stack and input source around the controller.
// Assumes the bench steers its condition variables by non-blocking assignment.
`timescale 1ns/100ps
module cterm_batt_model (
    input wire logic charger_enable_in,
    output cterm_pkg::cterm_sense_t sense_out
);
    logic [6:1] bad = 6'h00;
    logic cv = 1'b0;
    logic pause = 1'b0;
    logic rech = 1'b0;
    logic low35 = 1'b0;
    logic below1v = 1'b0;
    logic [15:0] bat_cur = 16'h0100;

    ////////////////////////////////////////////////////////////////////////////
    // A collapsed input also drags the input comparators low, as a real source would.
    always_comb begin
        sense_out.aux_supply_good = !bad[1];
        sense_out.input_above_minimum = !bad[2] && !below1v;
        sense_out.input_above_battery = !bad[3] && !below1v;
        sense_out.input_hyst_ok = !bad[3] && !below1v;
        sense_out.freq_resistor_missing = bad[4];
        sense_out.cell_strap_error = bad[5];
        sense_out.overheat = bad[6];
        sense_out.thermistor_pause = pause;
        sense_out.constant_voltage = cv;
        sense_out.below_recharge = rech;
        sense_out.below_35pct = low35;
        sense_out.input_below_1v = below1v;
        // No drive means no battery current, so taper cannot be faked while off.
        sense_out.battery_current = charger_enable_in ? bat_cur : 16'h0000;
        sense_out.full_current = 16'h0100;
    end
endmodule

// ===== tb/tb_charge_termination_control.sv
// Self-checking bench for the charge termination controller.
// Assumes a shortened second of four clocks, so one minute is 240 clocks.
`timescale 1ns/100ps
module tb_charge_termination_control;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    cterm_pkg::cterm_bus_t bus_in = '0;
    cterm_pkg::cterm_sense_t sense;
    logic [15:0] reg_rdata_out;
    logic charger_enable_out;
    logic suspended_out;
    logic alert_b_out;
    logic storage_mode_out;
    int num_errors = 0;
    int total_checks = 0;

    cterm_top #(.SEC_CYCLES(4)) i_cterm_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .bus_in(bus_in), .sense_in(sense), .reg_rdata_out(reg_rdata_out),
        .charger_enable_out(charger_enable_out), .suspended_out(suspended_out),
        .alert_b_out(alert_b_out), .storage_mode_out(storage_mode_out));
    cterm_batt_model i_cterm_batt_model (.charger_enable_in(charger_enable_out),
        .sense_out(sense));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 clk_in = ~clk_in;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_in <= '0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_in <= '0;
        #1;
        d = reg_rdata_out;
    endtask

    task automatic wait_out(input string what, ref logic sig, input logic val, input int n);
        int i = 0;
        #1;
        while (sig !== val && i < n) begin
            @(posedge clk_in);
            #1;
            i++;
        end
        check(what, {15'h0, val}, {15'h0, sig});
    endtask

    task automatic pulse_rech();
        @(posedge clk_in);
        i_cterm_batt_model.rech <= 1'b1;
        @(posedge clk_in);
        i_cterm_batt_model.rech <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        logic [15:0] v;
        logic [15:0] exp [0:7];
        exp = '{16'h0000, 16'h3840, 16'h0000, 16'h000a, 16'h0000, 16'h0000, 16'h0000,
            16'h0000};
        wr_reg(4'h7, 16'h1234);
        wr_reg(cterm_pkg::ADDR_VHOLD_TIMER, 16'h00ff);
        for (int a = 0; a < 8; a++) begin
            if (a != 4) begin
                rd_reg(a[3:0], v);
                check("reset register", exp[a], v);
            end
        end
        wait_out("charging after reset", charger_enable_out, 1'b1, 4);
        $display("test reset done");
    endtask

    task automatic test_hold();
        logic [15:0] v;
        wr_reg(cterm_pkg::ADDR_CTRL, 16'h0008);
        wr_reg(cterm_pkg::ADDR_CHARGE_LIMIT, 16'h0064);
        cyc(300);
        rd_reg(cterm_pkg::ADDR_CHARGE_TIMER, v);
        check("elapsed minutes", 16'h0001, v);
        wr_reg(cterm_pkg::ADDR_VHOLD_LIMIT, 16'h0005);
        @(posedge clk_in);
        i_cterm_batt_model.cv <= 1'b1;
        cyc(8);
        check("drive during hold", 16'h0001, {15'h0, charger_enable_out});
        rd_reg(cterm_pkg::ADDR_VHOLD_TIMER, v);
        check("hold seconds", 16'h0001, {15'h0, v >= 16'h1 && v <= 16'h3});
        wait_out("hold expiry", charger_enable_out, 1'b0, 16);
        rd_reg(cterm_pkg::ADDR_STATUS, v);
        check("hold flag", 16'h0012, v & 16'h007f);
        rd_reg(cterm_pkg::ADDR_CHARGE_TIMER, v);
        check("elapsed cleared", 16'h0000, v);
        check("hold alert", 16'h0000, {15'h0, alert_b_out});
        wr_reg(cterm_pkg::ADDR_STATUS, 16'h0002);
        cyc(2);
        check("alert cleared", 16'h0001, {15'h0, alert_b_out});
        cyc(20);
        check("stays off", 16'h0000, {15'h0, charger_enable_out});
        $display("test hold done");
    endtask

    task automatic test_recharge();
        logic [15:0] a;
        logic [15:0] b;
        wr_reg(cterm_pkg::ADDR_VHOLD_LIMIT, 16'h0064);
        @(posedge clk_in);
        i_cterm_batt_model.cv <= 1'b0;
        pulse_rech();
        wait_out("recharge", charger_enable_out, 1'b1, 4);
        rd_reg(cterm_pkg::ADDR_VHOLD_TIMER, a);
        check("hold timer zeroed", 16'h0000, a);
        @(posedge clk_in);
        i_cterm_batt_model.cv <= 1'b1;
        cyc(10);
        @(posedge clk_in);
        i_cterm_batt_model.pause <= 1'b1;
        cyc(2);
        rd_reg(cterm_pkg::ADDR_VHOLD_TIMER, a);
        cyc(20);
        rd_reg(cterm_pkg::ADDR_VHOLD_TIMER, b);
        check("frozen in pause", a, b);
        check("count kept", 16'h0001, {15'h0, a != 16'h0});
        @(posedge clk_in);
        i_cterm_batt_model.pause <= 1'b0;
        cyc(12);
        rd_reg(cterm_pkg::ADDR_VHOLD_TIMER, b);
        check("counts again", 16'h0001, {15'h0, b > a});
        $display("test recharge done");
    endtask

    task automatic test_taper();
        logic [15:0] v;
        wr_reg(cterm_pkg::ADDR_CTRL, 16'h0005);
        @(posedge clk_in);
        i_cterm_batt_model.bat_cur <= 16'h001a;
        cyc(10);
        check("above taper", 16'h0001, {15'h0, charger_enable_out});
        @(posedge clk_in);
        i_cterm_batt_model.bat_cur <= 16'h0019;
        wait_out("taper end", charger_enable_out, 1'b0, 4);
        rd_reg(cterm_pkg::ADDR_STATUS, v);
        check("taper flag", 16'h0011, v & 16'h007f);
        check("taper alert", 16'h0000, {15'h0, alert_b_out});
        wr_reg(cterm_pkg::ADDR_STATUS, 16'h0001);
        @(posedge clk_in);
        i_cterm_batt_model.cv <= 1'b0;
        i_cterm_batt_model.bat_cur <= 16'h0100;
        pulse_rech();
        wait_out("restart after taper", charger_enable_out, 1'b1, 4);
        $display("test taper done");
    endtask

    task automatic test_fault();
        logic [15:0] v;
        wr_reg(cterm_pkg::ADDR_CTRL, 16'h0010);
        wr_reg(cterm_pkg::ADDR_CHARGE_LIMIT, 16'h0001);
        cyc(200);
        check("before limit", 16'h0001, {15'h0, charger_enable_out});
        wait_out("charge fault", charger_enable_out, 1'b0, 100);
        rd_reg(cterm_pkg::ADDR_STATUS, v);
        check("fault flag", 16'h0004, v & 16'h007f);
        check("fault alert", 16'h0000, {15'h0, alert_b_out});
        pulse_rech();
        cyc(5);
        check("fault holds", 16'h0000, {15'h0, charger_enable_out});
        wr_reg(cterm_pkg::ADDR_CHARGE_LIMIT, 16'h0000);
        @(posedge clk_in);
        i_cterm_batt_model.low35 <= 1'b1;
        @(posedge clk_in);
        i_cterm_batt_model.low35 <= 1'b0;
        wait_out("new cycle", charger_enable_out, 1'b1, 4);
        rd_reg(cterm_pkg::ADDR_STATUS, v);
        check("fault cleared", 16'h0000, v & 16'h0004);
        $display("test fault done");
    endtask

    task automatic test_suspend();
        for (int k = 0; k < 7; k++) begin
            if (k == 0) begin
                wr_reg(cterm_pkg::ADDR_CTRL, 16'h0002);
            end else begin
                @(posedge clk_in);
                i_cterm_batt_model.bad[k] <= 1'b1;
            end
            wait_out("suspended", suspended_out, 1'b1, 3);
            check("drive off", 16'h0000, {15'h0, charger_enable_out});
            if (k == 0) begin
                wr_reg(cterm_pkg::ADDR_CTRL, 16'h0000);
            end else begin
                @(posedge clk_in);
                i_cterm_batt_model.bad[k] <= 1'b0;
            end
            wait_out("resumed", charger_enable_out, 1'b1, 5);
        end
        $display("test suspend done");
    endtask

    task automatic test_storage();
        logic [15:0] v;
        wr_reg(cterm_pkg::ADDR_VHOLD_LIMIT, 16'h0007);
        wr_reg(cterm_pkg::ADDR_CTRL, 16'h0020);
        cyc(5);
        check("arm only", 16'h0000, {15'h0, storage_mode_out});
        rd_reg(cterm_pkg::ADDR_STATUS, v);
        check("armed", 16'h0060, v & 16'h007f);
        @(posedge clk_in);
        i_cterm_batt_model.below1v <= 1'b1;
        wait_out("enter storage", storage_mode_out, 1'b1, 3);
        check("storage drive", 16'h0000, {15'h0, charger_enable_out});
        @(posedge clk_in);
        i_cterm_batt_model.below1v <= 1'b0;
        wait_out("wake", storage_mode_out, 1'b0, 3);
        cyc(3);
        rd_reg(cterm_pkg::ADDR_VHOLD_LIMIT, v);
        check("limit lost", 16'h3840, v);
        rd_reg(cterm_pkg::ADDR_CTRL, v);
        check("control lost", 16'h0000, v);
        $display("test storage done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // The tests need about 800 clocks.
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        test_reset();
        test_hold();
        test_recharge();
        test_taper();
        test_fault();
        test_suspend();
        test_storage();
        complete_run();
    end
endmodule
